// ===== logic/stepper_current_jog_control.sv
// current, idle delay, comm error, anti-resonance and jog logic of the drive block
//
// How it works
// - running current 0..5 A, 0.01 A steps
// - running write sets idle to half
// - idle above 90% of running clamps
// - idle delay 0..10 s before idle current
// - step pulse restarts idle delay timer in step/dir mode only
// - comm error vector readable, not retained
// - error bits: framing, noise, overrun, full flags
// - 63 command buffer, overflow sets overrun
// - filter frequency 1..2000 Hz stored
// - filter gain 0..32767 stored
// - jog start ramps to jog speed
// - jog stop decelerates at jog decel
// - fast stop decelerates at max accel
// - direction latched when jogging starts
// - speed change leaves stored jog speed
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`include "stepper_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module stepper_current_jog_control #(
  parameter int unsigned IDLE_TICK = `IDLE_TICK_CYC,
  parameter int unsigned RAMP_DIV = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic step_pulse_i,
  input wire logic step_dir_mode_i,
  input wire logic motion_done_i,
  input wire logic framing_err_i,
  input wire logic noise_err_i,
  input wire logic tx_full_i,
  input wire logic rx_cmd_push_i,
  input wire logic rx_cmd_pop_i,
  output logic [15:0] phase_current_o,
  output logic [15:0] antires_freq_o,
  output logic [15:0] antires_gain_o,
  output logic [15:0] jog_velocity_o,
  output logic jog_dir_o,
  output logic jog_active_o,
  output logic comm_err_o
);

  // ****************************************
  // helpers
  // ****************************************
  // saturate an incoming value to an upper bound
  function automatic logic [15:0] clamp_hi(input logic [15:0] v, input logic [15:0] hi);
    clamp_hi = (v > hi) ? hi : v;
  endfunction

  // 90% limit of a running current, floored to hundredths
  function automatic logic [15:0] ninety_pct(input logic [15:0] run);
    logic [19:0] p;
    p = 20'(run) * 20'd9;
    ninety_pct = 16'(p / 20'd10);
  endfunction

  // step a velocity toward a target by a rate, never overshooting
  function automatic logic [15:0] ramp(input logic [15:0] v, input logic [15:0] t,
                                       input logic [15:0] r);
    logic [16:0] s;
    s = 17'd0;
    if (v < t) begin
      s = 17'(v) + 17'(r);
      ramp = (s > 17'(t)) ? t : s[15:0];
    end else begin
      ramp = (v - t > r) ? v - r : t;
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  // three stages: the first feeds only the second, change seen when 2nd and 3rd agree
  logic [2:0] step_s1_q, step_s2_q, step_s3_q;
  logic [2:0] step_s1_d, step_s2_d, step_s3_d;
  logic step_clean_q, step_clean_d;
  logic frm_clean_q, frm_clean_d;
  logic noi_clean_q, noi_clean_d;

  always_comb begin
    step_s1_d = {step_pulse_i, framing_err_i, noise_err_i};
    step_s2_d = step_s1_q;
    step_s3_d = step_s2_q;
    step_clean_d = (step_s2_q[2] == step_s3_q[2]) ? step_s3_q[2] : step_clean_q;
    frm_clean_d = (step_s2_q[1] == step_s3_q[1]) ? step_s3_q[1] : frm_clean_q;
    noi_clean_d = (step_s2_q[0] == step_s3_q[0]) ? step_s3_q[0] : noi_clean_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_s1_q <= 3'h0;
      step_s2_q <= 3'h0;
      step_s3_q <= 3'h0;
      step_clean_q <= 1'b0;
      frm_clean_q <= 1'b0;
      noi_clean_q <= 1'b0;
    end else begin
      step_s1_q <= step_s1_d;
      step_s2_q <= step_s2_d;
      step_s3_q <= step_s3_d;
      step_clean_q <= step_clean_d;
      frm_clean_q <= frm_clean_d;
      noi_clean_q <= noi_clean_d;
    end
  end

  logic step_rise, frm_rise, noi_rise;
  assign step_rise = step_clean_d & ~step_clean_q;
  assign frm_rise = frm_clean_d & ~frm_clean_q;
  assign noi_rise = noi_clean_d & ~noi_clean_q;

  // ****************************************
  // wishbone slave
  // ****************************************
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic wr_en, rd_en;

  // one wait state: answer in the cycle after the request is seen
  assign wr_en = cyc_i & stb_i & we_i & ~ack_q;
  assign rd_en = cyc_i & stb_i & ~we_i & ~ack_q;
  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // byte-lane merge onto a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // parameter registers
  // ****************************************
  // note: retention across power cycles lives in external nonvolatile store
  logic [15:0] run_cur_q, run_cur_d, idle_cur_q, idle_cur_d, idle_dly_q, idle_dly_d;
  logic [15:0] ar_freq_q, ar_freq_d, ar_gain_q, ar_gain_d;
  logic [15:0] jog_spd_q, jog_spd_d, jog_acc_q, jog_acc_d, jog_dec_q, jog_dec_d;
  logic [15:0] max_acc_q, max_acc_d, spd_chg_q, spd_chg_d;
  logic dir_q, dir_d, chg_dir_q, chg_dir_d;
  logic jog_start, jog_stop, fast_stop, spd_chg_wr, err_clr;
  logic [15:0] wv;

  always_comb begin
    run_cur_d = run_cur_q;
    idle_cur_d = idle_cur_q;
    idle_dly_d = idle_dly_q;
    ar_freq_d = ar_freq_q;
    ar_gain_d = ar_gain_q;
    jog_spd_d = jog_spd_q;
    jog_acc_d = jog_acc_q;
    jog_dec_d = jog_dec_q;
    max_acc_d = max_acc_q;
    dir_d = dir_q;
    spd_chg_d = spd_chg_q;
    chg_dir_d = chg_dir_q;
    jog_start = 1'b0;
    jog_stop = 1'b0;
    fast_stop = 1'b0;
    spd_chg_wr = 1'b0;
    err_clr = 1'b0;
    wv = 16'h0000;
    // writes are stored silently; reads return the live value
    if (wr_en) begin
      unique case (adr_i)
        `ADR_RUN_CUR: begin
          wv = clamp_hi(merge16(run_cur_q, dat_i, sel_i), `RUN_CUR_MAX);
          run_cur_d = wv;
          idle_cur_d = wv >> 1;
        end
        `ADR_IDLE_CUR: begin
          wv = merge16(idle_cur_q, dat_i, sel_i);
          idle_cur_d = (wv > ninety_pct(run_cur_q)) ? ninety_pct(run_cur_q) : wv;
        end
        `ADR_IDLE_DLY: idle_dly_d = clamp_hi(merge16(idle_dly_q, dat_i, sel_i),
                                             `IDLE_DLY_MAX);
        `ADR_AR_FREQ: begin
          wv = clamp_hi(merge16(ar_freq_q, dat_i, sel_i), `AR_FREQ_MAX);
          ar_freq_d = (wv < `AR_FREQ_MIN) ? `AR_FREQ_MIN : wv;
        end
        `ADR_AR_GAIN: ar_gain_d = clamp_hi(merge16(ar_gain_q, dat_i, sel_i),
                                           `AR_GAIN_MAX);
        `ADR_JOG_SPD: jog_spd_d = merge16(jog_spd_q, dat_i, sel_i);
        `ADR_JOG_ACC: jog_acc_d = merge16(jog_acc_q, dat_i, sel_i);
        `ADR_JOG_DEC: jog_dec_d = merge16(jog_dec_q, dat_i, sel_i);
        `ADR_MAX_ACC: max_acc_d = merge16(max_acc_q, dat_i, sel_i);
        `ADR_DIR: if (sel_i[0]) dir_d = dat_i[0];
        `ADR_JOG_CTL: if (sel_i[0]) begin
          jog_start = dat_i[`CTL_JOG_START];
          jog_stop = dat_i[`CTL_JOG_STOP];
          fast_stop = dat_i[`CTL_FAST_STOP];
        end
        `ADR_SPD_CHG: begin
          spd_chg_d = merge16(spd_chg_q, dat_i, sel_i);
          if (sel_i[2]) chg_dir_d = dat_i[16];
          spd_chg_wr = 1'b1;
        end
        `ADR_ERR_CLR: err_clr = sel_i[0] & dat_i[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_cur_q <= `RST_RUN_CUR;
      idle_cur_q <= `RST_IDLE_CUR;
      idle_dly_q <= 16'h0000;
      ar_freq_q <= `RST_AR_FREQ;
      ar_gain_q <= 16'h0000;
      jog_spd_q <= 16'h0000;
      jog_acc_q <= 16'h0001;
      jog_dec_q <= 16'h0001;
      max_acc_q <= 16'h0001;
      dir_q <= 1'b0;
      spd_chg_q <= 16'h0000;
      chg_dir_q <= 1'b0;
    end else begin
      run_cur_q <= run_cur_d;
      idle_cur_q <= idle_cur_d;
      idle_dly_q <= idle_dly_d;
      ar_freq_q <= ar_freq_d;
      ar_gain_q <= ar_gain_d;
      jog_spd_q <= jog_spd_d;
      jog_acc_q <= jog_acc_d;
      jog_dec_q <= jog_dec_d;
      max_acc_q <= max_acc_d;
      dir_q <= dir_d;
      spd_chg_q <= spd_chg_d;
      chg_dir_q <= chg_dir_d;
    end
  end

  // ****************************************
  // idle current delay
  // ****************************************
  // tick every 10 ms; delay counts ticks in hundredths of a second
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic [15:0] dly_cnt_q, dly_cnt_d;
  logic idle_q, idle_d;
  logic moving;

  assign moving = jog_active_o | ~motion_done_i;

  always_comb begin
    tick_cnt_d = tick_cnt_q;
    dly_cnt_d = dly_cnt_q;
    idle_d = idle_q;
    if (moving || (step_dir_mode_i && step_rise)) begin
      tick_cnt_d = 32'h0;
      dly_cnt_d = 16'h0;
      idle_d = 1'b0;
    end else if (!idle_q) begin
      if (dly_cnt_q >= idle_dly_q) begin
        idle_d = 1'b1;
      end else if (tick_cnt_q == IDLE_TICK - 1) begin
        tick_cnt_d = 32'h0;
        dly_cnt_d = dly_cnt_q + 16'd1;
      end else begin
        tick_cnt_d = tick_cnt_q + 32'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= 32'h0;
      dly_cnt_q <= 16'h0;
      idle_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      dly_cnt_q <= dly_cnt_d;
      idle_q <= idle_d;
    end
  end

  // ****************************************
  // communication error vector
  // ****************************************
  // volatile; hardware set wins over software clear
  logic [5:0] err_q, err_d;
  logic [6:0] rx_cnt_q, rx_cnt_d;
  logic rx_push_ok;

  assign rx_push_ok = rx_cmd_push_i & (rx_cnt_q < `RX_CMD_DEPTH);

  always_comb begin
    err_d = err_clr ? 6'h00 : err_q;
    rx_cnt_d = rx_cnt_q + 7'(rx_push_ok) - 7'(rx_cmd_pop_i && rx_cnt_q != 7'd0);
    if (frm_rise) err_d[`ERR_FRAMING] = 1'b1;
    if (noi_rise) err_d[`ERR_NOISE] = 1'b1;
    if (rx_cmd_push_i && !rx_push_ok) err_d[`ERR_OVERRUN] = 1'b1;
    if (rx_cnt_d == `RX_CMD_DEPTH) err_d[`ERR_RX_FULL] = 1'b1;
    if (tx_full_i) err_d[`ERR_TX_FULL] = 1'b1;
    err_d[0] = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 6'h00;
      rx_cnt_q <= 7'h00;
    end else begin
      err_q <= err_d;
      rx_cnt_q <= rx_cnt_d;
    end
  end

  assign comm_err_o = |err_q;

  // ****************************************
  // jog machine
  // ****************************************
  stepper_pkg::jog_state_e st_q, st_d;
  logic [15:0] vel_q, vel_d, tgt_q, tgt_d, rate_q, rate_d;
  logic jdir_q, jdir_d;
  logic [15:0] div_q, div_d;
  logic rstep;

  // ramp steps every RAMP_DIV cycles so rates stay in a useful range
  assign rstep = (div_q == 16'(RAMP_DIV - 1));

  always_comb begin
    st_d = st_q;
    vel_d = vel_q;
    tgt_d = tgt_q;
    rate_d = rate_q;
    jdir_d = jdir_q;
    div_d = rstep ? 16'h0 : div_q + 16'd1;
    unique case (st_q)
      stepper_pkg::JOG_IDLE: if (jog_start) begin
        st_d = stepper_pkg::JOG_ACCEL;
        tgt_d = jog_spd_q;
        rate_d = jog_acc_q;
        jdir_d = dir_q;
        vel_d = 16'h0;
      end
      stepper_pkg::JOG_ACCEL, stepper_pkg::JOG_RUN: begin
        if (spd_chg_wr) begin
          tgt_d = spd_chg_d;
          rate_d = jog_acc_q;
          st_d = stepper_pkg::JOG_ACCEL;
        end
        if (rstep) vel_d = ramp(vel_q, tgt_q, rate_q);
        if (vel_q == tgt_q && !spd_chg_wr) st_d = stepper_pkg::JOG_RUN;
        // direction flip waits until rest to avoid reversing at speed
        if (spd_chg_wr && chg_dir_d != jdir_q) tgt_d = 16'h0;
        if (vel_q == 16'h0 && chg_dir_q != jdir_q && tgt_q == 16'h0 && spd_chg_q != 16'h0) begin
          jdir_d = chg_dir_q;
          tgt_d = spd_chg_q;
        end
      end
      stepper_pkg::JOG_DECEL: begin
        if (rstep) vel_d = ramp(vel_q, 16'h0, rate_q);
        if (vel_q == 16'h0) st_d = stepper_pkg::JOG_IDLE;
      end
    endcase
    if (st_q != stepper_pkg::JOG_IDLE) begin
      if (fast_stop) begin
        st_d = stepper_pkg::JOG_DECEL;
        rate_d = max_acc_q;
      end else if (jog_stop && st_q != stepper_pkg::JOG_DECEL) begin
        st_d = stepper_pkg::JOG_DECEL;
        rate_d = jog_dec_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= stepper_pkg::JOG_IDLE;
      vel_q <= 16'h0;
      tgt_q <= 16'h0;
      rate_q <= 16'h1;
      jdir_q <= 1'b0;
      div_q <= 16'h0;
    end else begin
      st_q <= st_d;
      vel_q <= vel_d;
      tgt_q <= tgt_d;
      rate_q <= rate_d;
      jdir_q <= jdir_d;
      div_q <= div_d;
    end
  end

  // ****************************************
  // read mux and outputs
  // ****************************************
  always_comb begin
    ack_d = cyc_i & stb_i & ~ack_q;
    rdat_d = rdat_q;
    if (rd_en) begin
      unique case (adr_i)
        `ADR_RUN_CUR: rdat_d = {16'h0, run_cur_q};
        `ADR_IDLE_CUR: rdat_d = {16'h0, idle_cur_q};
        `ADR_IDLE_DLY: rdat_d = {16'h0, idle_dly_q};
        `ADR_COMM_ERR: rdat_d = {26'h0, err_q};
        `ADR_AR_FREQ: rdat_d = {16'h0, ar_freq_q};
        `ADR_AR_GAIN: rdat_d = {16'h0, ar_gain_q};
        `ADR_JOG_SPD: rdat_d = {16'h0, jog_spd_q};
        `ADR_JOG_ACC: rdat_d = {16'h0, jog_acc_q};
        `ADR_JOG_DEC: rdat_d = {16'h0, jog_dec_q};
        `ADR_MAX_ACC: rdat_d = {16'h0, max_acc_q};
        `ADR_DIR: rdat_d = {31'h0, dir_q};
        `ADR_SPD_CHG: rdat_d = {15'h0, chg_dir_q, spd_chg_q};
        `ADR_STATUS: rdat_d = {26'h0, comm_err_o, idle_q, jdir_q, 1'b0, st_q};
        default: rdat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // phase current follows idle state; filter, velocity and direction outputs straight from flip-flops
  assign phase_current_o = idle_q ? idle_cur_q : run_cur_q;
  assign antires_freq_o = ar_freq_q;
  assign antires_gain_o = ar_gain_q;
  assign jog_velocity_o = vel_q;
  assign jog_dir_o = jdir_q;
  assign jog_active_o = (st_q != stepper_pkg::JOG_IDLE);

endmodule
`default_nettype wire

// ===== logic/stepper_consts.svh
// register offsets, field positions, reset values and timing counts for the drive block
`ifndef STEPPER_CONSTS_SVH
`define STEPPER_CONSTS_SVH
// ****************************************
// register byte addresses
// ****************************************
`define ADR_RUN_CUR 8'h00
`define ADR_IDLE_CUR 8'h04
`define ADR_IDLE_DLY 8'h08
`define ADR_COMM_ERR 8'h0c
`define ADR_AR_FREQ 8'h10
`define ADR_AR_GAIN 8'h14
`define ADR_JOG_SPD 8'h18
`define ADR_JOG_ACC 8'h1c
`define ADR_JOG_DEC 8'h20
`define ADR_MAX_ACC 8'h24
`define ADR_DIR 8'h28
`define ADR_JOG_CTL 8'h2c
`define ADR_SPD_CHG 8'h30
`define ADR_STATUS 8'h34
`define ADR_ERR_CLR 8'h38
// ****************************************
// field positions and limits
// ****************************************
`define ERR_FRAMING 1
`define ERR_NOISE 2
`define ERR_OVERRUN 3
`define ERR_RX_FULL 4
`define ERR_TX_FULL 5
`define CTL_JOG_START 0
`define CTL_JOG_STOP 1
`define CTL_FAST_STOP 2
`define RUN_CUR_MAX 16'd500
`define IDLE_DLY_MAX 16'd1000
`define AR_FREQ_MIN 16'd1
`define AR_FREQ_MAX 16'd2000
`define AR_GAIN_MAX 16'd32767
`define RX_CMD_DEPTH 7'd63
// ****************************************
// reset values and timing
// ****************************************
`define RST_RUN_CUR 16'd0
`define RST_IDLE_CUR 16'd0
`define RST_AR_FREQ 16'd1
`define IDLE_TICK_MS 10
`define CLK_HZ 25000000
`define IDLE_TICK_CYC ((`CLK_HZ / 1000) * `IDLE_TICK_MS)
`endif

// ===== logic/stepper_pkg.sv
// types shared by the drive block
package stepper_pkg;
  typedef enum logic [1:0] {
    JOG_IDLE,
    JOG_ACCEL,
    JOG_RUN,
    JOG_DECEL
  } jog_state_e;
endpackage

// ===== verif/stepper_ctl_checker.sv
// concurrent checks on the ports of the drive control block
`timescale 1ns/100ps
`default_nettype none
module stepper_ctl_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic ack_o,
  input wire logic [15:0] phase_current_o,
  input wire logic [15:0] antires_freq_o,
  input wire logic [15:0] antires_gain_o,
  input wire logic [15:0] jog_velocity_o,
  input wire logic jog_dir_o,
  input wire logic jog_active_o,
  input wire logic comm_err_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_one_wait: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_run_cur_max: assert property (phase_current_o <= 16'd500)
    else $error("phase current above limit");
  a_freq_range: assert property (antires_freq_o >= 16'd1 && antires_freq_o <= 16'd2000)
    else $error("filter frequency out of range");
  a_gain_max: assert property (antires_gain_o <= 16'd32767)
    else $error("filter gain out of range");
  a_freq_hold: assert property (!(cyc_i && stb_i && we_i) |=> $stable(antires_freq_o))
    else $error("filter frequency changed without write");
  // only a taken write to the clear address may drop the sticky flag
  a_err_sticky: assert property ((comm_err_o && !(cyc_i && stb_i && we_i && adr_i == 8'h38))
    |=> comm_err_o)
    else $error("error flag dropped without clear");
  a_idle_no_vel: assert property (!jog_active_o |-> jog_velocity_o == 16'h0000)
    else $error("velocity nonzero while not jogging");
  a_dir_hold: assert property ((jog_active_o && $past(jog_active_o) && jog_velocity_o != 0
    && $past(jog_velocity_o) != 0) |-> $stable(jog_dir_o))
    else $error("direction changed while moving");
  c_jog: cover property (jog_active_o ##1 !jog_active_o);
  c_err: cover property ($rose(comm_err_o));
  c_wr: cover property (cyc_i && we_i && ack_o);
endmodule
bind stepper_current_jog_control stepper_ctl_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .ack_o(ack_o),
  .phase_current_o(phase_current_o), .antires_freq_o(antires_freq_o),
  .antires_gain_o(antires_gain_o), .jog_velocity_o(jog_velocity_o), .jog_dir_o(jog_dir_o),
  .jog_active_o(jog_active_o), .comm_err_o(comm_err_o));
`default_nettype wire

// ===== verif/host_link_model.sv
// model of the serial front end that feeds error events and commands to the block
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
  input wire logic clk_i,
  output logic framing_err_o,
  output logic noise_err_o,
  output logic tx_full_o,
  output logic push_o,
  output logic pop_o
);
  // ****************************************
  // event generation
  // ****************************************
  initial begin
    framing_err_o = 1'b0;
    noise_err_o = 1'b0;
    tx_full_o = 1'b0;
    push_o = 1'b0;
    pop_o = 1'b0;
  end
  // error pulses held two cycles so the synchroniser cannot miss them
  task automatic line_err(input logic noisy);
    @(posedge clk_i);
    if (noisy) noise_err_o <= 1'b1; else framing_err_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    noise_err_o <= 1'b0;
    framing_err_o <= 1'b0;
  endtask
  // host keeps sending without waiting for room, one command per cycle
  task automatic push_n(input int n);
    @(posedge clk_i);
    push_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    push_o <= 1'b0;
  endtask
  // host pulls commands out of the buffer, one per cycle
  task automatic pop_n(input int n);
    @(posedge clk_i);
    pop_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    pop_o <= 1'b0;
  endtask
  task automatic set_tx_full(input logic v);
    @(posedge clk_i);
    tx_full_o <= v;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the drive control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, step_pulse_i, step_dir_mode_i, motion_done_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i, lanes;
  logic [31:0] dat_i, dat_o, rd;
  logic ack_o, jog_dir_o, jog_active_o, comm_err_o, fe, ne, txf, push, pop;
  logic [15:0] phase_current_o, antires_freq_o, antires_gain_o, jog_velocity_o;
  int n_errors, comparisons, t_stop, t_fast;
  stepper_current_jog_control #(.IDLE_TICK(4), .RAMP_DIV(2)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .step_pulse_i(step_pulse_i),
    .step_dir_mode_i(step_dir_mode_i), .motion_done_i(motion_done_i), .framing_err_i(fe),
    .noise_err_i(ne), .tx_full_i(txf), .rx_cmd_push_i(push), .rx_cmd_pop_i(pop),
    .phase_current_o(phase_current_o), .antires_freq_o(antires_freq_o),
    .antires_gain_o(antires_gain_o), .jog_velocity_o(jog_velocity_o), .jog_dir_o(jog_dir_o),
    .jog_active_o(jog_active_o), .comm_err_o(comm_err_o));
  host_link_model link (.clk_i(clk_i), .framing_err_o(fe), .noise_err_o(ne), .tx_full_o(txf),
    .push_o(push), .pop_o(pop));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold everything until ack is seen, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= lanes;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("ERROR %0t bus timeout", $time);
      close_out();
    end
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_vel(input logic [15:0] v, output int n);
    n = 0;
    while (jog_velocity_o !== v && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    // a ramp that never arrives is a failure, not a silent end
    if (n >= 2000) begin
      n_errors++;
      $display("ERROR %0t velocity timeout", $time);
      close_out();
    end
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {cyc_i, stb_i, we_i, step_pulse_i, step_dir_mode_i} = '0;
    motion_done_i = 1'b1;
    adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0;
    lanes = 4'hf;
    n_errors = 0; comparisons = 0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h10, 32'h1);
    rchk(8'h3c, 32'h0);
    wb(1'b1, 8'h00, 32'd300);
    rchk(8'h00, 32'd300);
    rchk(8'h04, 32'd150);
    wb(1'b1, 8'h00, 32'd600);
    rchk(8'h00, 32'd500);
    rchk(8'h04, 32'd250);
    wb(1'b1, 8'h04, 32'd480);
    rchk(8'h04, 32'd450);
    wb(1'b1, 8'h04, 32'd100);
    rchk(8'h04, 32'd100);
    wb(1'b1, 8'h10, 32'd0);
    rchk(8'h10, 32'd1);
    wb(1'b1, 8'h10, 32'd2500);
    rchk(8'h10, 32'd2000);
    chk({16'h0, antires_freq_o}, 32'd2000);
    wb(1'b1, 8'h14, 32'd32767);
    rchk(8'h14, 32'd32767);
    chk({16'h0, antires_gain_o}, 32'd32767);
    // low byte lane only: the high byte must keep its old value
    lanes = 4'h1;
    wb(1'b1, 8'h14, 32'h1234);
    lanes = 4'hf;
    rchk(8'h14, 32'h7f34);
    $display("test params done");
    wb(1'b1, 8'h00, 32'd300);
    wb(1'b1, 8'h08, 32'd3);
    rchk(8'h08, 32'd3);
    motion_done_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({16'h0, phase_current_o}, 32'd300);
    motion_done_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({16'h0, phase_current_o}, 32'd300);
    repeat (30) @(posedge clk_i);
    chk({16'h0, phase_current_o}, 32'd150);
    step_dir_mode_i <= 1'b1;
    repeat (6) begin
      @(posedge clk_i) step_pulse_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      step_pulse_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({16'h0, phase_current_o}, 32'd300);
    end
    repeat (40) @(posedge clk_i);
    chk({16'h0, phase_current_o}, 32'd150);
    step_dir_mode_i <= 1'b0;
    $display("test idle done");
    link.line_err(1'b0);
    repeat (6) @(posedge clk_i);
    rchk(8'h0c, 32'h02);
    link.line_err(1'b1);
    repeat (6) @(posedge clk_i);
    wb(1'b1, 8'h0c, 32'hff);
    rchk(8'h0c, 32'h06);
    chk({31'h0, comm_err_o}, 32'h1);
    rchk(8'h34, 32'h30);
    link.set_tx_full(1'b1);
    link.set_tx_full(1'b0);
    link.push_n(64);
    // drain two so the full level no longer re-arms its bit after the clear
    link.pop_n(2);
    rchk(8'h0c, 32'h3e);
    wb(1'b1, 8'h38, 32'h1);
    rchk(8'h0c, 32'h00);
    $display("test errors done");
    wb(1'b1, 8'h18, 32'd20);
    wb(1'b1, 8'h1c, 32'd4);
    wb(1'b1, 8'h20, 32'd2);
    wb(1'b1, 8'h24, 32'd10);
    wb(1'b1, 8'h28, 32'd1);
    wb(1'b1, 8'h2c, 32'h1);
    wait_vel(16'd20, t_stop);
    chk({31'h0, jog_dir_o}, 32'h1);
    rchk(8'h34, 32'h0a);
    wb(1'b1, 8'h28, 32'd0);
    chk({31'h0, jog_dir_o}, 32'h1);
    wb(1'b1, 8'h30, 32'h1001e);
    wait_vel(16'd30, t_stop);
    rchk(8'h18, 32'd20);
    wb(1'b1, 8'h2c, 32'h2);
    wait_vel(16'd0, t_stop);
    chk({31'h0, t_stop >= 25}, 32'h1);
    wb(1'b1, 8'h2c, 32'h1);
    wait_vel(16'd20, t_fast);
    chk({31'h0, jog_dir_o}, 32'h0);
    // reverse on the fly: ramp to rest, then back up the other way
    wb(1'b1, 8'h30, 32'h10014);
    wait_vel(16'd0, t_stop);
    wait_vel(16'd20, t_stop);
    chk({31'h0, jog_dir_o}, 32'h1);
    wb(1'b1, 8'h2c, 32'h4);
    wait_vel(16'd0, t_fast);
    chk({31'h0, t_fast <= 10}, 32'h1);
    repeat (4) @(posedge clk_i);
    chk({31'h0, jog_active_o}, 32'h0);
    $display("test jog done");
    close_out();
  end
endmodule
`default_nettype wire
